// file: logic/acmp_params.svh
/*
 Constants for the two-channel analog comparator control block.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef ACMP_PARAMS_SVH
`define ACMP_PARAMS_SVH
`define ACMP_NUM_UNITS 2
`define ACMP_SRC_POS_A 2'h0
`define ACMP_SRC_POS_B 2'h1
`define ACMP_SRC_VREF 2'h2
`define ACMP_SRC_RSVD 2'h3
`define ACMP_EDGE_LOW 3'h0
`define ACMP_EDGE_HIGH 3'h1
`define ACMP_EDGE_FALL 3'h2
`define ACMP_EDGE_RISE 3'h3
`define ACMP_EDGE_BOTH 3'h4
`endif

// file: logic/acmp_pkg.sv
/*
 Types for the analog comparator control block.
 Assumes acmp_params.svh is on the include path.
*/
`include "acmp_params.svh"
package acmp_pkg;
   typedef logic [1:0] acmp_src_t;
   typedef logic [2:0] acmp_sense_t;
endpackage : acmp_pkg

// file: logic/acmp_ctrl.sv
/*
 Digital control around two analog comparators: positive-input source select,
 result synchronisation, interrupt and ADC-trigger event generation.
 Assumes the analog cores sit outside; their raw results arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acmp_params.svh"

module acmp_ctrl
   import acmp_pkg::*;
#(
   parameter int NUM_UNITS = `ACMP_NUM_UNITS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] src_sel0,
   input wire logic [1:0] src_sel1,
   input wire logic [2:0] irq_sense0,
   input wire logic [2:0] irq_sense1,
   input wire logic [2:0] trig_sense0,
   input wire logic [2:0] trig_sense1,
   input wire logic [1:0] trig_en,
   input wire logic [1:0] out_en,
   input wire logic [1:0] irq_enable,
   input wire logic [1:0] irq_clear,
   input wire logic [1:0] raw_result,
   output logic [1:0] pos_mux_sel0,
   output logic [1:0] pos_mux_sel1,
   output logic [1:0] compare_result,
   output logic [1:0] raw_irq_status,
   output logic [1:0] masked_irq_status,
   output logic irq,
   output logic [1:0] adc_trigger,
   output logic comp0_out_pin,
   output logic comp1_out_pin,
   output logic comp1_out_pin_oe
);

   if (NUM_UNITS != 2) begin : g_bad_units
      $error("acmp_ctrl serves exactly two units");
   end

   acmp_src_t src_sel [2];
   acmp_sense_t irq_sense [2];
   acmp_sense_t trig_sense [2];
   assign src_sel[0] = src_sel0;
   assign src_sel[1] = src_sel1;
   assign irq_sense[0] = irq_sense0;
   assign irq_sense[1] = irq_sense1;
   assign trig_sense[0] = trig_sense0;
   assign trig_sense[1] = trig_sense1;

   // Analog mux steering; the negative input has no mux, always the own pin
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pos_mux_sel0 <= `ACMP_SRC_POS_A;
         pos_mux_sel1 <= `ACMP_SRC_POS_A;
      end else begin
         pos_mux_sel0 <= (src_sel0 == `ACMP_SRC_POS_B) ? `ACMP_SRC_POS_A : src_sel0;
         pos_mux_sel1 <= src_sel1;
      end
   end

   logic [1:0] sync1_r;
   logic [1:0] sync2_r;
   logic [1:0] prev_r;
   logic [1:0] raw_irq_r;
   logic [1:0] trig_r;
   logic [1:0] out_r;
   logic [1:0] irq_evt;
   logic [1:0] trig_evt;

   function automatic logic sense_hit(input acmp_sense_t s, input logic cur, input logic prv);
      case (s)
         `ACMP_EDGE_LOW: sense_hit = !cur;
         `ACMP_EDGE_HIGH: sense_hit = cur;
         `ACMP_EDGE_FALL: sense_hit = prv && !cur;
         `ACMP_EDGE_RISE: sense_hit = !prv && cur;
         `ACMP_EDGE_BOTH: sense_hit = prv ^ cur;
         default: sense_hit = 1'b0;
      endcase
   endfunction : sense_hit

   // Synchroniser; the analog result can change at any moment
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_r <= 2'h0;
         sync2_r <= 2'h0;
         prev_r <= 2'h0;
      end else begin
         sync1_r <= raw_result;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_unit
         // Separate senses let interrupt and trigger watch different edges
         assign irq_evt[g] = sense_hit(irq_sense[g], sync2_r[g], prev_r[g]);
         assign trig_evt[g] = trig_en[g] && sense_hit(trig_sense[g], sync2_r[g], prev_r[g]);

         // Set wins over clear so an event in the clear cycle is kept
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               raw_irq_r[g] <= 1'b0;
            end else if (irq_evt[g]) begin
               raw_irq_r[g] <= 1'b1;
            end else if (irq_clear[g]) begin
               raw_irq_r[g] <= 1'b0;
            end
         end

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               trig_r[g] <= 1'b0;
               out_r[g] <= 1'b0;
            end else begin
               trig_r[g] <= trig_evt[g];
               out_r[g] <= out_en[g] && sync2_r[g];
            end
         end
      end
   endgenerate

   assign compare_result = sync2_r;
   assign raw_irq_status = raw_irq_r;
   assign masked_irq_status = raw_irq_r & irq_enable;
   assign irq = |masked_irq_status;
   assign adc_trigger = trig_r;
   assign comp0_out_pin = out_r[0];
   assign comp1_out_pin = out_r[1];
   // Request and registered mux must both be off the pin, so a select change never overlaps a drive
   assign comp1_out_pin_oe = out_en[1] && (src_sel1 != `ACMP_SRC_POS_A)
      && (pos_mux_sel1 != `ACMP_SRC_POS_A);

   property p_sync_delay;
      // The synchroniser stages only carry the input once both have left reset
      @(posedge clk) disable iff (rst)
         (!$past(rst, 1) && !$past(rst, 2)) |-> compare_result == $past(raw_result, 2);
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("result not two-flop delayed");

   property p_raw_set;
      @(posedge clk) disable iff (rst) irq_evt[0] |=> raw_irq_status[0];
   endproperty
   a_raw_set: assert property (p_raw_set) else $error("raw status 0 missed event");

   property p_raw_set1;
      @(posedge clk) disable iff (rst) irq_evt[1] |=> raw_irq_status[1];
   endproperty
   a_raw_set1: assert property (p_raw_set1) else $error("raw status 1 missed event");

   property p_masked;
      @(posedge clk) disable iff (rst) masked_irq_status == (raw_irq_status & irq_enable);
   endproperty
   a_masked: assert property (p_masked) else $error("masked status mismatch");

   property p_rise_trig;
      @(posedge clk) disable iff (rst)
         (trig_en[1] && trig_sense1 == `ACMP_EDGE_RISE && $rose(compare_result[1])) |=> adc_trigger[1];
   endproperty
   a_rise_trig: assert property (p_rise_trig) else $error("rising trigger missed");

   property p_trig_off;
      @(posedge clk) disable iff (rst) !trig_en[1] |=> !adc_trigger[1];
   endproperty
   a_trig_off: assert property (p_trig_off) else $error("trigger while disabled");

   property p_sel0;
      @(posedge clk) disable iff (rst) (src_sel0 == `ACMP_SRC_VREF) |=> pos_mux_sel0 == `ACMP_SRC_VREF;
   endproperty
   a_sel0: assert property (p_sel0) else $error("unit 0 reference not selected");

   property p_sel1;
      @(posedge clk) disable iff (rst) (src_sel1 == `ACMP_SRC_POS_B) |=> pos_mux_sel1 == `ACMP_SRC_POS_B;
   endproperty
   a_sel1: assert property (p_sel1) else $error("unit 1 source not followed");

   property p_shared_pin;
      @(posedge clk) disable iff (rst) (pos_mux_sel1 == `ACMP_SRC_POS_A) |-> !comp1_out_pin_oe;
   endproperty
   a_shared_pin: assert property (p_shared_pin) else $error("shared pin driven as input");

   property p_sel0_alias;
      @(posedge clk) disable iff (rst) (src_sel0 == `ACMP_SRC_POS_B) |=> pos_mux_sel0 == `ACMP_SRC_POS_A;
   endproperty
   a_sel0_alias: assert property (p_sel0_alias) else $error("unit 0 alias select not folded");

   property p_raw_clear;
      @(posedge clk) disable iff (rst) (irq_clear[0] && !irq_evt[0]) |=> !raw_irq_status[0];
   endproperty
   a_raw_clear: assert property (p_raw_clear) else $error("raw status 0 not cleared");

   property p_raw_hold;
      @(posedge clk) disable iff (rst) (raw_irq_status[1] && !irq_clear[1]) |=> raw_irq_status[1];
   endproperty
   a_raw_hold: assert property (p_raw_hold) else $error("raw status 1 lost without clear");

   property p_fall_trig;
      @(posedge clk) disable iff (rst)
         (trig_en[0] && trig_sense0 == `ACMP_EDGE_FALL && $fell(compare_result[0])) |=> adc_trigger[0];
   endproperty
   a_fall_trig: assert property (p_fall_trig) else $error("falling trigger missed");

   property p_trig_pulse;
      @(posedge clk) disable iff (rst)
         (trig_sense1 == `ACMP_EDGE_RISE && $past(trig_sense1) == `ACMP_EDGE_RISE && adc_trigger[1]) |=> !adc_trigger[1];
   endproperty
   a_trig_pulse: assert property (p_trig_pulse) else $error("edge trigger longer than one cycle");

   property p_out_pin;
      @(posedge clk) disable iff (rst) comp0_out_pin == $past(out_en[0] && compare_result[0]);
   endproperty
   a_out_pin: assert property (p_out_pin) else $error("unit 0 output pin not following result");

endmodule : acmp_ctrl
`default_nettype wire

// file: dv/acmp_analog_model.sv
/*
 Behavioural analog cores: picks each positive input from the mux selects and compares it with the own negative pin.
 Assumes pin voltages arrive as unsigned codes from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module acmp_analog_model (
   input wire logic [1:0] pos_mux_sel0,
   input wire logic [1:0] pos_mux_sel1,
   input wire logic comp1_out_pin_oe,
   input wire logic [7:0] v_neg0,
   input wire logic [7:0] v_neg1,
   input wire logic [7:0] v_pos0,
   input wire logic [7:0] v_pos1,
   input wire logic [7:0] v_ref,
   output logic [1:0] raw_result
);
   logic [7:0] pos0;
   logic [7:0] pos1;
   always_comb begin
      pos0 = (pos_mux_sel0 == 2'h2) ? v_ref : ((pos_mux_sel0 == 2'h3) ? 8'h00 : v_pos0);
      case (pos_mux_sel1)
         2'h0: pos1 = comp1_out_pin_oe ? 8'h00 : v_pos1;
         2'h1: pos1 = v_pos0;
         2'h2: pos1 = v_ref;
         default: pos1 = 8'h00;
      endcase
      raw_result = {pos1 > v_neg1, pos0 > v_neg0};
   end
endmodule : acmp_analog_model
`default_nettype wire

// file: dv/test_analog_comparator_control.sv
/*
 Testbench for acmp_ctrl with the analog model in front of it.
 Assumes the package and acmp_params.svh are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; $display("BAD %0t value mismatch", $time); end end
module test_analog_comparator_control;
   import acmp_pkg::*;
   logic clk, rst;
   logic [1:0] src_sel0, src_sel1, trig_en, out_en, irq_enable, irq_clear;
   logic [2:0] irq_sense0, irq_sense1, trig_sense0, trig_sense1;
   logic [7:0] v_neg0 = 8'h80, v_neg1 = 8'h80, v_pos0 = 8'h90, v_pos1 = 8'h70, v_ref = 8'h70;
   wire logic [1:0] raw_result, pos_mux_sel0, pos_mux_sel1, compare_result, raw_irq_status, masked_irq_status, adc_trigger;
   wire logic irq, comp0_out_pin, comp1_out_pin, comp1_out_pin_oe;
   int err_total = 0, check_count = 0, hits0, hits1;
   logic [1:0] exp_res [4] = '{2'h1, 2'h3, 2'h0, 2'h0};
   acmp_ctrl dut (.clk(clk), .rst(rst), .src_sel0(src_sel0), .src_sel1(src_sel1), .irq_sense0(irq_sense0),
      .irq_sense1(irq_sense1), .trig_sense0(trig_sense0), .trig_sense1(trig_sense1), .trig_en(trig_en),
      .out_en(out_en), .irq_enable(irq_enable), .irq_clear(irq_clear), .raw_result(raw_result),
      .pos_mux_sel0(pos_mux_sel0), .pos_mux_sel1(pos_mux_sel1), .compare_result(compare_result),
      .raw_irq_status(raw_irq_status), .masked_irq_status(masked_irq_status), .irq(irq),
      .adc_trigger(adc_trigger), .comp0_out_pin(comp0_out_pin), .comp1_out_pin(comp1_out_pin),
      .comp1_out_pin_oe(comp1_out_pin_oe));
   acmp_analog_model model (.pos_mux_sel0(pos_mux_sel0), .pos_mux_sel1(pos_mux_sel1),
      .comp1_out_pin_oe(comp1_out_pin_oe), .v_neg0(v_neg0), .v_neg1(v_neg1), .v_pos0(v_pos0), .v_pos1(v_pos1),
      .v_ref(v_ref), .raw_result(raw_result));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Writes both selects, then counts trigger pulses while the result settles
   task set_src(input logic [1:0] s0, input logic [1:0] s1);
      @(posedge clk);
      src_sel0 <= s0;
      src_sel1 <= s1;
      hits0 = 0;
      hits1 = 0;
      repeat (7) begin
         @(negedge clk);
         hits0 += int'(adc_trigger[0] === 1'b1);
         hits1 += int'(adc_trigger[1] === 1'b1);
      end
   endtask : set_src
   task complete_run;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   initial begin
      repeat (2000) @(posedge clk);
      err_total++;
      complete_run;
   end
   initial begin
      rst = 1'b1;
      {src_sel0, src_sel1, trig_en, out_en, irq_enable, irq_clear} = '0;
      {irq_sense0, irq_sense1, trig_sense0, trig_sense1} = {4{3'h7}};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK({raw_irq_status, adc_trigger, compare_result}, 6'h00)
      for (int s = 0; s < 4; s++) begin
         set_src(s[1:0], s[1:0]);
         `CHK(pos_mux_sel0, (s == 1) ? 2'h0 : s[1:0])
         `CHK(pos_mux_sel1, s[1:0])
         `CHK(compare_result, exp_res[s])
      end
      `CHK(raw_irq_status, 2'h0)
      @(posedge clk);
      {irq_sense0, trig_sense0, irq_sense1, trig_sense1} <= {3'h3, 3'h2, 3'h4, 3'h3};
      trig_en <= 2'h3;
      out_en <= 2'h3;
      set_src(2'h0, 2'h1);
      `CHK({hits0, hits1}, {32'd0, 32'd1})
      `CHK({raw_irq_status, masked_irq_status, irq}, 5'b11000)
      `CHK({comp0_out_pin, comp1_out_pin, comp1_out_pin_oe}, 3'b111)
      @(posedge clk) irq_enable <= 2'h1;
      @(negedge clk);
      `CHK({masked_irq_status, irq}, 3'b011)
      @(posedge clk) irq_clear <= 2'h3;
      @(posedge clk) irq_clear <= 2'h0;
      @(negedge clk);
      `CHK({raw_irq_status, irq}, 3'b000)
      set_src(2'h2, 2'h2);
      `CHK({hits0, hits1}, {32'd1, 32'd0})
      `CHK({raw_irq_status, masked_irq_status, irq}, 5'b10000)
      set_src(2'h0, 2'h0);
      `CHK({comp1_out_pin_oe, compare_result}, 3'b001)
      // Level sense on unit 0 sets in the clear cycle and must win; unit 1 has no event and clears
      @(posedge clk);
      {irq_sense0, irq_sense1} <= {3'h1, 3'h7};
      irq_clear <= 2'h3;
      @(posedge clk);
      @(negedge clk);
      `CHK(raw_irq_status, 2'h1)
      @(posedge clk);
      {irq_sense0, irq_sense1, irq_clear} <= {3'h7, 3'h0, 2'h0};
      {v_neg0, v_neg1} <= {8'hff, 8'h60};
      repeat (4) @(negedge clk);
      `CHK(raw_irq_status, 2'h3)
      `CHK({compare_result, comp1_out_pin, comp0_out_pin}, 4'ha)
      complete_run;
   end
endmodule : test_analog_comparator_control
`default_nettype wire
